// *** rtl/igmp_sched.sv ***
// Pending IGMP messages and the periodic report timer.
// Assumes grant pulses once when the shown message is taken.
`default_nettype none
module igmp_sched #(
  parameter int REPORT_CYCLES = socket_pkg::REPORT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic active,
  input wire logic joinReq,
  input wire logic leaveReq,
  input wire logic grant,
  output logic reqValid,
  output socket_pkg::frame_kind_t reqKind
);
  typedef struct packed {
    logic joinPend;
    logic leavePend;
    logic reportPend;
    logic [31:0] timer;
  } sched_t;
  sched_t s;
  sched_t next_s;

  always_comb begin
    next_s = s;
    if (grant) begin
      case (reqKind)
        socket_pkg::KIND_LEAVE: next_s.leavePend = 1'b0;
        socket_pkg::KIND_JOIN: next_s.joinPend = 1'b0;
        socket_pkg::KIND_REPORT: next_s.reportPend = 1'b0;
        default: next_s.reportPend = s.reportPend;
      endcase
    end
    // Reports repeat while the group socket stays open
    if (!active) begin
      next_s.timer = 32'(REPORT_CYCLES - 1);
      next_s.reportPend = 1'b0;
    end else if (s.timer == '0) begin
      next_s.timer = 32'(REPORT_CYCLES - 1);
      next_s.reportPend = 1'b1;
    end else begin
      next_s.timer = s.timer - 1'b1;
    end
    if (joinReq) begin
      next_s.joinPend = 1'b1;
      next_s.leavePend = 1'b0;
    end
    if (leaveReq) begin
      next_s.leavePend = 1'b1;
      next_s.joinPend = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reqValid = s.joinPend || s.leavePend || s.reportPend;
  assign reqKind = s.leavePend ? socket_pkg::KIND_LEAVE :
                   s.joinPend ? socket_pkg::KIND_JOIN : socket_pkg::KIND_REPORT;
endmodule
`default_nettype wire

// *** rtl/socket_mode_engine.sv ***
// Socket engine for multicast datagram, network raw and link raw modes.
// Assumes a host register port and a network side that frames and parses packets.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`default_nettype none
module socket_mode_engine #(
  parameter int SOCKET_INDEX = 0,
  parameter int IGMP_VERSION = 2,
  parameter int REPORT_CYCLES = socket_pkg::REPORT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdData,
  output logic txValid,
  output logic [1:0] txKind,
  output logic txNeedsArp,
  output logic [7:0] txIpProto,
  output logic [31:0] txDestIp,
  output logic [47:0] txDestMac,
  output logic [15:0] txDestPort,
  output logic [15:0] txSrcPort,
  output logic [15:0] txLenBytes,
  output logic [1:0] txIgmpVersion,
  input wire logic txAccept,
  output logic txWordValid,
  output logic [15:0] txWordData,
  input wire logic txWordReady,
  input wire logic rxStart,
  input wire logic [1:0] rxClass,
  input wire logic [7:0] rxIpProto,
  input wire logic [31:0] rxSrcIp,
  input wire logic [15:0] rxSrcPort,
  input wire logic [15:0] rxDestPort,
  input wire logic [15:0] rxLenBytes,
  input wire logic rxFragmented,
  input wire logic rxClaimedByOthers,
  input wire logic rxWordValid,
  input wire logic [15:0] rxWordData,
  output logic rxWordReady,
  output logic rxDropped
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] state;
    logic [7:0] proto;
    logic send_complete_flag;
    logic sendPend;
    logic [15:0] dport;
    logic [15:0] sport;
    logic [31:0] dip;
    logic [47:0] dmac;
    logic [15:0] txWrSize;
    logic [15:0] rdData;
    socket_pkg::tx_phase_t txPhase;
    socket_pkg::frame_kind_t kind;
    logic [15:0] txWordsLeft;
    socket_pkg::rx_phase_t rxPhase;
    logic [1:0] hdrIdx;
    logic [15:0] rxWordsLeft;
    logic [31:0] rxIp;
    logic [15:0] rxPort;
    logic [15:0] rxLen;
    logic rxDrop;
  } engine_t;
  engine_t s;
  engine_t next_s;
  word_store_if txIf();
  word_store_if rxIf();
  logic igmpValid;
  socket_pkg::frame_kind_t igmpKind;
  logic igmpGrant;
  logic joinReq;
  logic leaveReq;
  logic multiOpen;
  logic [3:0] protoSel;
  logic [15:0] rdMux;
  logic [15:0] hdrWord;
  logic [15:0] needWords;
  logic [15:0] dataWords;
  logic matchOk;

  word_store txStore (.clk(clk), .sys_rst(sys_rst), .port(txIf.store));
  word_store rxStore (.clk(clk), .sys_rst(sys_rst), .port(rxIf.store));
  igmp_sched #(.REPORT_CYCLES(REPORT_CYCLES)) igmp (
    .clk(clk), .sys_rst(sys_rst), .active(multiOpen), .joinReq(joinReq),
    .leaveReq(leaveReq), .grant(igmpGrant), .reqValid(igmpValid), .reqKind(igmpKind)
  );

  assign protoSel = s.mode[3:0];
  assign multiOpen = (s.state == socket_pkg::STATE_DATAGRAM_OPEN)
                     && s.mode[socket_pkg::MODE_MULTI_BIT];
  assign igmpGrant = (s.txPhase == socket_pkg::TX_HDR) && txAccept
                     && (s.kind != socket_pkg::KIND_DATA);

  // Register read mux
  always_comb begin
    case (regAddr)
      socket_pkg::OFS_MODE: rdMux = {8'h00, s.mode};
      socket_pkg::OFS_IRQ: rdMux = 16'(s.send_complete_flag) << socket_pkg::IRQ_SEND_BIT;
      socket_pkg::OFS_STATE: rdMux = {8'h00, s.state};
      socket_pkg::OFS_PROTO: rdMux = {8'h00, s.proto};
      socket_pkg::OFS_TX_FREE: rdMux = 16'({txIf.free, 1'b0});
      socket_pkg::OFS_TX_WRSIZE: rdMux = s.txWrSize;
      socket_pkg::OFS_RX_FIFO: rdMux = rxIf.popData;
      socket_pkg::OFS_RX_USED: rdMux = 16'({rxIf.used, 1'b0});
      socket_pkg::OFS_DPORT: rdMux = s.dport;
      socket_pkg::OFS_SPORT: rdMux = s.sport;
      socket_pkg::OFS_DIP_HI: rdMux = s.dip[31:16];
      socket_pkg::OFS_DIP_LO: rdMux = s.dip[15:0];
      socket_pkg::OFS_DMAC_HI: rdMux = s.dmac[47:32];
      socket_pkg::OFS_DMAC_MID: rdMux = s.dmac[31:16];
      socket_pkg::OFS_DMAC_LO: rdMux = s.dmac[15:0];
      default: rdMux = 16'h0000;
    endcase
  end

  // Receive header words, in store order
  always_comb begin
    case (s.hdrIdx)
      2'd0: hdrWord = s.rxIp[31:16];
      2'd1: hdrWord = s.rxIp[15:0];
      2'd2: hdrWord = s.rxPort;
      default: hdrWord = s.rxLen;
    endcase
  end

  // Admission of a received packet
  always_comb begin
    dataWords = 16'((17'(rxLenBytes) + 17'h00001) >> 1);
    matchOk = 1'b0;
    needWords = dataWords;
    case (s.state)
      socket_pkg::STATE_DATAGRAM_OPEN: begin
        matchOk = (rxClass == socket_pkg::RXK_UDP) && (rxDestPort == s.sport)
                  && !rxFragmented;
        needWords = dataWords + 16'h0004;
      end
      socket_pkg::STATE_NETWORK_RAW_OPEN: begin
        matchOk = (rxClass == socket_pkg::RXK_IP) && (rxIpProto == s.proto)
                  && !rxFragmented;
        needWords = dataWords + 16'h0003;
      end
      socket_pkg::STATE_LINK_RAW_OPEN: begin
        matchOk = (rxClass == socket_pkg::RXK_ETH) && !rxClaimedByOthers;
        needWords = dataWords + 16'h0001 + 16'(socket_pkg::CRC_WORDS);
      end
      default: matchOk = 1'b0;
    endcase
    if (needWords > 16'(rxIf.free)) begin
      matchOk = 1'b0;
    end
  end

  always_comb begin
    next_s = s;
    next_s.rdData = regRead ? rdMux : 16'h0000;
    next_s.rxDrop = 1'b0;
    joinReq = 1'b0;
    leaveReq = 1'b0;
    txIf.push = 1'b0;
    txIf.pushData = regWrData;
    txIf.pop = 1'b0;
    txIf.flush = 1'b0;
    rxIf.push = 1'b0;
    rxIf.pushData = rxWordData;
    rxIf.pop = regRead && (regAddr == socket_pkg::OFS_RX_FIFO);
    rxIf.flush = 1'b0;
    rxWordReady = 1'b0;
    if (regWrite) begin
      case (regAddr)
        socket_pkg::OFS_MODE: next_s.mode = regWrData[7:0];
        socket_pkg::OFS_PROTO: next_s.proto = regWrData[7:0];
        socket_pkg::OFS_TX_WRSIZE: next_s.txWrSize = regWrData;
        socket_pkg::OFS_TX_FIFO: txIf.push = 1'b1;
        socket_pkg::OFS_DPORT: next_s.dport = regWrData;
        socket_pkg::OFS_SPORT: next_s.sport = regWrData;
        socket_pkg::OFS_DIP_HI: next_s.dip[31:16] = regWrData;
        socket_pkg::OFS_DIP_LO: next_s.dip[15:0] = regWrData;
        socket_pkg::OFS_DMAC_HI: next_s.dmac[47:32] = regWrData;
        socket_pkg::OFS_DMAC_MID: next_s.dmac[31:16] = regWrData;
        socket_pkg::OFS_DMAC_LO: next_s.dmac[15:0] = regWrData;
        socket_pkg::OFS_IRQ: begin
          if (regWrData[socket_pkg::IRQ_SEND_BIT]) begin
            next_s.send_complete_flag = 1'b0;
          end
        end
        socket_pkg::OFS_CMD: begin
          case (regWrData[7:0])
            socket_pkg::CMD_OPEN: begin
              if (s.state == socket_pkg::STATE_CLOSED) begin
                case (protoSel)
                  socket_pkg::PROTO_UDP: begin
                    next_s.state = socket_pkg::STATE_DATAGRAM_OPEN;
                    joinReq = s.mode[socket_pkg::MODE_MULTI_BIT];
                  end
                  socket_pkg::PROTO_NET_RAW: begin
                    if (s.proto != socket_pkg::IPP_TCP
                        && s.proto != socket_pkg::IPP_UDP) begin
                      next_s.state = socket_pkg::STATE_NETWORK_RAW_OPEN;
                    end
                  end
                  socket_pkg::PROTO_LINK_RAW: begin
                    if (SOCKET_INDEX == 0) begin
                      next_s.state = socket_pkg::STATE_LINK_RAW_OPEN;
                    end
                  end
                  default: next_s.state = socket_pkg::STATE_CLOSED;
                endcase
              end
            end
            socket_pkg::CMD_CLOSE: begin
              next_s.state = socket_pkg::STATE_CLOSED;
              next_s.sendPend = 1'b0;
              txIf.flush = 1'b1;
              rxIf.flush = 1'b1;
              leaveReq = multiOpen && (IGMP_VERSION == 2);
            end
            socket_pkg::CMD_SEND: begin
              next_s.sendPend = (s.state != socket_pkg::STATE_CLOSED);
            end
            default: next_s.sendPend = s.sendPend;
          endcase
        end
        default: next_s.mode = s.mode;
      endcase
    end
    // Transmit sequencer; IGMP messages go ahead of data
    case (s.txPhase)
      socket_pkg::TX_IDLE: begin
        if (igmpValid) begin
          next_s.kind = igmpKind;
          next_s.txPhase = socket_pkg::TX_HDR;
        end else if (s.sendPend) begin
          next_s.sendPend = 1'b0;
          next_s.kind = socket_pkg::KIND_DATA;
          next_s.txWordsLeft = 16'((17'(s.txWrSize) + 17'h00001) >> 1);
          next_s.txPhase = socket_pkg::TX_HDR;
        end
      end
      socket_pkg::TX_HDR: begin
        if (txAccept) begin
          if (s.kind == socket_pkg::KIND_DATA && s.txWordsLeft != '0) begin
            next_s.txPhase = socket_pkg::TX_BODY;
          end else begin
            next_s.txPhase = socket_pkg::TX_IDLE;
            next_s.send_complete_flag = (s.kind == socket_pkg::KIND_DATA) || next_s.send_complete_flag;
          end
        end
      end
      socket_pkg::TX_BODY: begin
        if (txWordReady && txIf.used != '0) begin
          txIf.pop = 1'b1;
          next_s.txWordsLeft = s.txWordsLeft - 1'b1;
          if (s.txWordsLeft == 16'h0001) begin
            next_s.txPhase = socket_pkg::TX_IDLE;
            next_s.send_complete_flag = 1'b1;
          end
        end
      end
      default: next_s.txPhase = socket_pkg::TX_IDLE;
    endcase
    // Receive sequencer
    case (s.rxPhase)
      socket_pkg::RX_IDLE: begin
        if (rxStart) begin
          next_s.rxIp = rxSrcIp;
          next_s.rxPort = rxSrcPort;
          next_s.rxLen = rxLenBytes;
          next_s.rxWordsLeft = dataWords;
          if (matchOk) begin
            next_s.rxPhase = socket_pkg::RX_HDR;
            case (s.state)
              socket_pkg::STATE_DATAGRAM_OPEN: next_s.hdrIdx = 2'd0;
              socket_pkg::STATE_NETWORK_RAW_OPEN: next_s.hdrIdx = 2'd0;
              default: begin
                next_s.hdrIdx = 2'd3;
                next_s.rxWordsLeft = dataWords + 16'(socket_pkg::CRC_WORDS);
              end
            endcase
          end else begin
            next_s.rxDrop = 1'b1;
            next_s.rxPhase = socket_pkg::RX_DROP;
            if (rxClass == socket_pkg::RXK_ETH) begin
              next_s.rxWordsLeft = dataWords + 16'(socket_pkg::CRC_WORDS);
            end
          end
        end
      end
      socket_pkg::RX_HDR: begin
        rxIf.push = 1'b1;
        rxIf.pushData = hdrWord;
        if (s.hdrIdx == 2'd1 && s.state == socket_pkg::STATE_NETWORK_RAW_OPEN) begin
          next_s.hdrIdx = 2'd3;
        end else begin
          next_s.hdrIdx = s.hdrIdx + 2'd1;
        end
        if (s.hdrIdx == 2'd3) begin
          next_s.rxPhase = (s.rxWordsLeft == '0) ? socket_pkg::RX_IDLE : socket_pkg::RX_BODY;
        end
      end
      socket_pkg::RX_BODY, socket_pkg::RX_DROP: begin
        rxWordReady = 1'b1;
        if (s.rxWordsLeft == '0) begin
          next_s.rxPhase = socket_pkg::RX_IDLE;
          rxWordReady = 1'b0;
        end else if (rxWordValid) begin
          rxIf.push = (s.rxPhase == socket_pkg::RX_BODY);
          next_s.rxWordsLeft = s.rxWordsLeft - 1'b1;
          if (s.rxWordsLeft == 16'h0001) begin
            next_s.rxPhase = socket_pkg::RX_IDLE;
          end
        end
      end
      default: next_s.rxPhase = socket_pkg::RX_IDLE;
    endcase
    if (regWrite && regAddr == socket_pkg::OFS_CMD && regWrData[7:0] == socket_pkg::CMD_CLOSE) begin
      next_s.txPhase = socket_pkg::TX_IDLE;
      next_s.rxPhase = socket_pkg::RX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign regRdData = s.rdData;
  assign rxDropped = s.rxDrop;
  assign txValid = (s.txPhase == socket_pkg::TX_HDR);
  assign txKind = s.kind;
  // Only unicast datagram and network raw sends resolve the peer address
  assign txNeedsArp = (s.kind == socket_pkg::KIND_DATA)
                      && (protoSel == socket_pkg::PROTO_NET_RAW
                          || (protoSel == socket_pkg::PROTO_UDP
                              && !s.mode[socket_pkg::MODE_MULTI_BIT]));
  assign txIpProto = (s.kind != socket_pkg::KIND_DATA) ? socket_pkg::IPP_IGMP :
                     (protoSel == socket_pkg::PROTO_NET_RAW) ? s.proto :
                     socket_pkg::IPP_UDP;
  assign txDestIp = s.dip;
  assign txDestMac = s.dmac;
  assign txDestPort = s.dport;
  assign txSrcPort = s.sport;
  assign txLenBytes = (s.kind == socket_pkg::KIND_DATA) ? s.txWrSize : 16'h0000;
  assign txIgmpVersion = 2'(IGMP_VERSION);
  assign txWordValid = (s.txPhase == socket_pkg::TX_BODY) && (txIf.used != '0);
  assign txWordData = txIf.popData;
endmodule
`default_nettype wire

// *** rtl/socket_pkg.sv ***
// Constants, register map and state types of the socket mode engine.
// Assumes a 200 MHz clock and a 16-bit host register port.
`default_nettype none
package socket_pkg;
  localparam int CLK_MHZ = 200;
  localparam int REPORT_PERIOD_MS = 1000;
  localparam int REPORT_CYCLES = REPORT_PERIOD_MS * CLK_MHZ * 1000;
  localparam int STORE_DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int CNT_W = 9;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h02;
  localparam logic [7:0] OFS_IRQ = 8'h04;
  localparam logic [7:0] OFS_STATE = 8'h06;
  localparam logic [7:0] OFS_PROTO = 8'h08;
  localparam logic [7:0] OFS_TX_FREE = 8'h0A;
  localparam logic [7:0] OFS_TX_WRSIZE = 8'h0C;
  localparam logic [7:0] OFS_TX_FIFO = 8'h0E;
  localparam logic [7:0] OFS_RX_FIFO = 8'h10;
  localparam logic [7:0] OFS_RX_USED = 8'h12;
  localparam logic [7:0] OFS_DPORT = 8'h14;
  localparam logic [7:0] OFS_SPORT = 8'h16;
  localparam logic [7:0] OFS_DIP_HI = 8'h18;
  localparam logic [7:0] OFS_DIP_LO = 8'h1A;
  localparam logic [7:0] OFS_DMAC_HI = 8'h1C;
  localparam logic [7:0] OFS_DMAC_MID = 8'h1E;
  localparam logic [7:0] OFS_DMAC_LO = 8'h20;
  // Mode and IRQ register fields
  localparam int MODE_MULTI_BIT = 7;
  localparam logic [3:0] PROTO_UDP = 4'h2;
  localparam logic [3:0] PROTO_NET_RAW = 4'h3;
  localparam logic [3:0] PROTO_LINK_RAW = 4'h4;
  localparam int IRQ_SEND_BIT = 4;
  // Commands
  localparam logic [7:0] CMD_OPEN = 8'h01;
  localparam logic [7:0] CMD_CLOSE = 8'h10;
  localparam logic [7:0] CMD_SEND = 8'h20;
  localparam logic [7:0] CMD_RECV = 8'h40;
  // Socket state codes
  localparam logic [7:0] STATE_CLOSED = 8'h00;
  localparam logic [7:0] STATE_DATAGRAM_OPEN = 8'h22;
  localparam logic [7:0] STATE_NETWORK_RAW_OPEN = 8'h32;
  localparam logic [7:0] STATE_LINK_RAW_OPEN = 8'h42;
  // IP protocol numbers
  localparam logic [7:0] IPP_TCP = 8'h06;
  localparam logic [7:0] IPP_UDP = 8'h11;
  localparam logic [7:0] IPP_IGMP = 8'h02;
  localparam int CRC_WORDS = 2;
  typedef enum logic [1:0] {KIND_DATA, KIND_JOIN, KIND_LEAVE, KIND_REPORT} frame_kind_t;
  typedef enum logic [1:0] {RXK_UDP, RXK_IP, RXK_ETH, RXK_OTHER} rx_class_t;
  typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_BODY} tx_phase_t;
  typedef enum logic [1:0] {RX_IDLE, RX_HDR, RX_BODY, RX_DROP} rx_phase_t;
endpackage
`default_nettype wire

// *** rtl/word_store.sv ***
// Flip-flop word buffer used for socket TX and RX memory.
// Assumes the owner never pushes when full nor pops when empty.
`default_nettype none
module word_store (
  input wire logic clk,
  input wire logic sys_rst,
  word_store_if.store port
);
  typedef struct packed {
    logic [socket_pkg::STORE_DEPTH-1:0][15:0] mem;
    logic [socket_pkg::PTR_W-1:0] wr;
    logic [socket_pkg::PTR_W-1:0] rd;
    logic [socket_pkg::CNT_W-1:0] count;
  } store_t;
  store_t s;
  store_t next_s;
  logic doPush;
  logic doPop;

  always_comb begin
    next_s = s;
    doPush = port.push && (s.count != socket_pkg::CNT_W'(socket_pkg::STORE_DEPTH));
    doPop = port.pop && (s.count != '0);
    if (doPush) begin
      next_s.mem[s.wr] = port.pushData;
      next_s.wr = s.wr + 1'b1;
    end
    if (doPop) begin
      next_s.rd = s.rd + 1'b1;
    end
    next_s.count = s.count + CNT_W1(doPush) - CNT_W1(doPop);
    if (port.flush) begin
      next_s.wr = '0;
      next_s.rd = '0;
      next_s.count = '0;
    end
  end

  function automatic logic [socket_pkg::CNT_W-1:0] CNT_W1(input logic b);
    CNT_W1 = {{(socket_pkg::CNT_W-1){1'b0}}, b};
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign port.popData = s.mem[s.rd];
  assign port.used = s.count;
  assign port.free = socket_pkg::CNT_W'(socket_pkg::STORE_DEPTH) - s.count;
endmodule
`default_nettype wire

// *** rtl/word_store_if.sv ***
// Link between the engine and one 16-bit word store.
// Assumes socket_pkg is compiled first.
`default_nettype none
interface word_store_if;
  logic push;
  logic [15:0] pushData;
  logic pop;
  logic flush;
  logic [15:0] popData;
  logic [socket_pkg::CNT_W-1:0] used;
  logic [socket_pkg::CNT_W-1:0] free;
  modport owner(output push, pushData, pop, flush, input popData, used, free);
  modport store(input push, pushData, pop, flush, output popData, used, free);
endinterface
`default_nettype wire

// *** verification/net_partner.sv ***
// Network side model: takes frame headers and payload words.
// Assumes the engine's tx ports on the same clock; slow halves word rate.
`default_nettype none
module net_partner (
  input wire logic clk,
  input wire logic slow,
  input wire logic txValid,
  input wire logic [1:0] txKind,
  input wire logic txNeedsArp,
  input wire logic txWordValid,
  output logic txAccept,
  output logic txWordReady,
  output logic [1:0] lastKind,
  output logic lastArp,
  output logic [15:0] words
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph;
  initial begin
    {ph, txAccept, txWordReady, lastKind, lastArp, words} = '0;
  end
  always @(posedge clk) begin
    ph <= ~ph;
    txAccept <= txValid && !txAccept;
    txWordReady <= slow ? ph : 1'b1;
    if (txValid && txAccept) begin
      lastKind <= txKind;
      if (txKind == 2'h0) lastArp <= txNeedsArp;
    end
    if (txWordValid && txWordReady) words <= words + 16'h1;
  end
endmodule
`default_nettype wire

// *** verification/socket_mode_engine_properties.sv ***
// Port-level assertions for the socket engine.
// Assumes binding into socket_mode_engine on its one clock.
`default_nettype none
module socket_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regRdData,
  input wire logic txValid,
  input wire logic [1:0] txKind,
  input wire logic [7:0] txIpProto,
  input wire logic [15:0] txLenBytes,
  input wire logic [1:0] txIgmpVersion,
  input wire logic txAccept,
  input wire logic txWordValid,
  input wire logic txWordReady,
  input wire logic rxStart,
  input wire logic rxDropped
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_igmp_proto: assert property (txValid && txKind != 2'h0 |-> txIpProto == 8'h02)
    else $error("igmp frame protocol wrong");
  a_report_empty: assert property (txValid && txKind == 2'h3 |-> txLenBytes == 16'h0)
    else $error("report carries payload");
  a_igmp_version: assert property (txIgmpVersion inside {2'h1, 2'h2})
    else $error("igmp version out of range");
  // A command write may abort the sequencer, so it is left out
  a_header_hold: assert property (txValid && !txAccept && !(regWrite && regAddr == 8'h02)
    |=> txValid && $stable(txKind))
    else $error("header dropped before accept");
  a_word_hold: assert property (txWordValid && !txWordReady && !(regWrite && regAddr == 8'h02)
    |=> txWordValid)
    else $error("word dropped before taken");
  a_drop_cause: assert property (rxDropped |-> $past(rxStart))
    else $error("drop without packet");
  a_drop_pulse: assert property (rxDropped |=> !rxDropped)
    else $error("drop pulse too long");
  a_read_idle: assert property (!$past(regRead) |-> regRdData == 16'h0)
    else $error("read data outside read slot");
endmodule
bind socket_mode_engine socket_checker socket_checker_i (.clk, .sys_rst, .regRead, .regRdData,
  .regWrite, .regAddr,
  .txValid, .txKind, .txIpProto, .txLenBytes, .txIgmpVersion, .txAccept, .txWordValid,
  .txWordReady, .rxStart, .rxDropped);
`default_nettype wire

// *** verification/socket_mode_engine_tb_top.sv ***
// Bench for socket_mode_engine: register tasks act as the host.
// Assumes net_partner on tx side; rx descriptors come from the bench.
`default_nettype none
module socket_mode_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, rxStart = 1'b0;
  logic rxFragmented = 1'b0, rxClaimedByOthers = 1'b0, rxWordValid = 1'b0, slow = 1'b0;
  logic txAccept, txWordReady, txValid, txNeedsArp, txWordValid;
  logic rxWordReady, rxDropped, lastArp;
  logic [7:0] regAddr = 8'h00, rxIpProto = 8'h00, txIpProto, lastProto = 8'h00;
  logic [15:0] regWrData = 16'h0000, regRdData, rxWordData = 16'h0000, words;
  logic [15:0] rxLenBytes = 16'h0002;
  logic [1:0] rxClass = 2'h1, txKind, lastKind;
  logic [23:0] cfg [7] = '{24'h1C0100, 24'h1E5E01, 24'h20010B, 24'h18E001, 24'h1A010B,
    24'h140BB8, 24'h160BB8};
  int failures = 0, total_checks = 0, drops = 0;
  socket_mode_engine #(.REPORT_CYCLES(50)) socket_mode_engine_i (.clk, .sys_rst, .regAddr,
    .regWrData, .regWrite, .regRead, .regRdData, .txValid, .txKind, .txNeedsArp,
    .txIpProto, .txDestIp(), .txDestMac(), .txDestPort(), .txSrcPort(), .txLenBytes(),
    .txIgmpVersion(), .txAccept, .txWordValid, .txWordData(), .txWordReady, .rxStart,
    .rxClass, .rxIpProto, .rxSrcIp(32'h0A000001), .rxSrcPort(16'h0000),
    .rxDestPort(16'h0BB8), .rxLenBytes, .rxFragmented, .rxClaimedByOthers, .rxWordValid,
    .rxWordData,
    .rxWordReady, .rxDropped);
  net_partner net_partner_i (.clk, .slow, .txValid, .txKind, .txNeedsArp, .txWordValid,
    .txAccept, .txWordReady, .lastKind, .lastArp, .words);
  always #2.5 clk = ~clk;
  always @(posedge clk) if (rxDropped === 1'b1) drops++;
  always @(posedge clk) if (txValid && txAccept && txKind == 2'h0) lastProto <= txIpProto;
  task automatic cmp(input string nm, input logic [15:0] e, s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 cmp($sformatf("reg %h", a), e, regRdData);
  endtask
  task automatic rx(input logic [7:0] p, input logic f, input logic [1:0] c, input logic o);
    @(posedge clk);
    rxIpProto <= p;
    rxFragmented <= f;
    rxClass <= c;
    rxClaimedByOthers <= o;
    rxStart <= 1'b1;
    @(posedge clk);
    rxStart <= 1'b0;
    rxWordValid <= 1'b1;
    repeat (20) @(posedge clk) rxWordData <= rxWordData + 16'h1;
    rxWordValid <= 1'b0;
  endtask
  task automatic summarize;
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #10000;
    failures++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h06, 16'h0000);
    rd(8'h0A, 16'h0200);
    rd(8'h30, 16'h0000);
    foreach (cfg[i]) wr(cfg[i][23:16], cfg[i][15:0]);
    wr(8'h00, 16'h0082);
    wr(8'h02, 16'h0001);
    rd(8'h06, 16'h0022);
    repeat (8) @(posedge clk);
    cmp("join", 16'h0001, {14'h0, lastKind});
    repeat (60) @(posedge clk);
    cmp("report", 16'h0003, {14'h0, lastKind});
    rx(8'h11, 1'b0, 2'h0, 1'b0);
    rd(8'h12, 16'h000A);
    rd(8'h10, 16'h0A00);
    slow <= 1'b1;
    repeat (3) wr(8'h0E, 16'hA1B2);
    wr(8'h0C, 16'h0005);
    wr(8'h02, 16'h0020);
    repeat (30) @(posedge clk);
    rd(8'h04, 16'h0010);
    cmp("words", 16'h0003, words);
    cmp("arp", 16'h0000, {15'h0, lastArp});
    wr(8'h04, 16'h0010);
    rd(8'h04, 16'h0000);
    rd(8'h0A, 16'h0200);
    wr(8'h02, 16'h0010);
    repeat (10) @(posedge clk);
    cmp("leave", 16'h0002, {14'h0, lastKind});
    wr(8'h08, 16'h0006);
    wr(8'h00, 16'h0003);
    wr(8'h02, 16'h0001);
    rd(8'h06, 16'h0000);
    wr(8'h08, 16'h0001);
    wr(8'h02, 16'h0001);
    rd(8'h06, 16'h0032);
    wr(8'h0E, 16'h4500);
    wr(8'h0C, 16'h0002);
    wr(8'h02, 16'h0020);
    repeat (8) @(posedge clk);
    cmp("proto", 16'h0001, {8'h00, lastProto});
    cmp("arp", 16'h0001, {15'h0, lastArp});
    rx(8'h01, 1'b0, 2'h1, 1'b0);
    rx(8'h02, 1'b0, 2'h1, 1'b0);
    rx(8'h01, 1'b1, 2'h1, 1'b0);
    rd(8'h12, 16'h0008);
    rd(8'h10, 16'h0A00);
    rd(8'h10, 16'h0001);
    rd(8'h10, 16'h0002);
    cmp("drops", 16'h0002, drops[15:0]);
    wr(8'h02, 16'h0010);
    wr(8'h00, 16'h0004);
    wr(8'h02, 16'h0001);
    rd(8'h06, 16'h0042);
    repeat (7) wr(8'h0E, 16'h0100);
    wr(8'h0C, 16'h000E);
    wr(8'h02, 16'h0020);
    repeat (24) @(posedge clk);
    cmp("words", 16'h000B, words);
    cmp("arp", 16'h0000, {15'h0, lastArp});
    rx(8'h00, 1'b0, 2'h2, 1'b1);
    rx(8'h00, 1'b0, 2'h2, 1'b0);
    rd(8'h12, 16'h0008);
    rd(8'h10, 16'h0002);
    cmp("drops", 16'h0003, drops[15:0]);
    summarize();
  end
endmodule
`default_nettype wire
